// file: include/sdc_params.svh
// offsets, field positions, reset values and counts of the spi frame engine
`ifndef SDC_PARAMS_SVH
`define SDC_PARAMS_SVH

// frame layout
`define SDC_FRAME_W 16
`define SDC_BYTE_W 8
`define SDC_BIT_RW 15
`define SDC_ADDR_HI 14
`define SDC_ADDR_LO 12
`define SDC_DATA_HI 11
`define SDC_BYTE_LAST_CNT 3'h7

// command address and the status snapshot code used after reset
`define SDC_ADDR_CMD 3'h0
`define SDC_SNAPSHOT_CMD 12'h710

// local register bus
`define SDC_BUS_AW 4
`define SDC_BUS_DW 16
`define SDC_REG_CTRL 4'h0
`define SDC_REG_STATUS 4'h1
`define SDC_REG_LAST_RX 4'h2
`define SDC_REG_LAST_TX 4'h3

// field positions and reset values
`define SDC_CTRL_SPLIT 0
`define SDC_STAT_ERR 0
`define SDC_STAT_BUSY 1
`define SDC_STAT_SPLIT 2
`define SDC_STAT_CNT_LO 8
`define SDC_CTRL_RST 1'b1

// pin synchroniser depth
`define SDC_SYNC_STAGES 2

`endif

// file: include/sdc_pkg.sv
// types shared by the spi frame engine and its users
`include "sdc_params.svh"

package sdc_pkg;

   // one 16-bit command toward the device registers
   typedef struct packed {
      logic wr;
      logic [2:0] addr;
      logic [11:0] data;
   } sdc_req_s;

   // answer of the byte command executor
   typedef struct packed {
      logic split;
      logic [7:0] data;
   } sdc_byte_ans_s;

   // local register bus request
   typedef struct packed {
      logic [`SDC_BUS_AW-1:0] addr;
      logic [`SDC_BUS_DW-1:0] wdata;
      logic wr;
      logic rd;
   } sdc_bus_s;

   typedef enum logic [2:0] {
      ST_BOOT,
      ST_IDLE,
      ST_SHIFT,
      ST_ASK,
      ST_LOAD
   } sdc_state_e;

endpackage : sdc_pkg

// file: core/sdc_pin_sync.sv
// per-pin synchroniser with edge detection on the settled level
`timescale 1ns/1ns
module sdc_pin_sync #(
   parameter int W = 3,
   parameter int STAGES = 2,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] lvl,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);

   // fewer than two stages would let metastability reach the logic
   if (STAGES < 2) begin : g_bad_stages
      $error("sdc_pin_sync needs at least two stages");
   end

   genvar i;
   // one chain per pin; the edge detector only sees the last stage
   for (i = 0; i < W; i++) begin : g_pin
      logic [STAGES-1:0] chain;
      logic last;
      always_ff @(posedge clk) begin
         if (srst) begin
            chain <= {STAGES{RST_VAL[i]}};
            last <= RST_VAL[i];
         end else begin
            chain <= {chain[STAGES-2:0], d_in[i]};
            last <= chain[STAGES-1];
         end
      end
      assign lvl[i] = chain[STAGES-1];
      assign rise[i] = chain[STAGES-1] & ~last;
      assign fall[i] = ~chain[STAGES-1] & last;
   end

endmodule : sdc_pin_sync

// file: core/sdc_spi_frame.sv
// spi slave frame engine: 16-bit and split protocol with chain pass-through
`timescale 1ns/1ns
`include "sdc_params.svh"

module sdc_spi_frame
   import sdc_pkg::*;
#(
   parameter int SYNC_STAGES = `SDC_SYNC_STAGES
) (
   input wire logic REF_CLK,
   input wire logic SRST,
   input wire logic CS_N,
   input wire logic SCLK,
   input wire logic SI,
   output logic SO_O,
   output logic SO_OE,
   input wire sdc_bus_s BUS,
   output logic [`SDC_BUS_DW-1:0] BUS_RDATA,
   output logic FRM_REQ,
   output sdc_req_s FRM_CMD,
   input wire logic [11:0] FRM_ANS,
   output logic BYTE_REQ,
   output logic BYTE_LAST,
   output logic [7:0] BYTE_CMD,
   input wire sdc_byte_ans_s BYTE_ANS,
   output logic COMM_ERR
);

   logic [2:0] pin_lvl;
   logic [2:0] pin_rise;
   logic [2:0] pin_fall;
   logic cs_n;
   logic cs_rise;
   logic cs_fall;
   logic sclk_rise;
   logic sclk_fall;
   logic si;

   sdc_state_e st;
   logic [15:0] sr;
   logic [15:0] out_frame;
   logic [15:0] last_rx;
   logic [2:0] mod8;
   logic got_byte;
   logic ge16;
   logic split_frame;
   logic up_pend;
   logic lo_kind;
   logic so_bit;
   logic split_en;
   logic comm_err;
   logic [7:0] frame_cnt;
   logic err_set;
   logic decode_ok;
   logic [7:0] upper_rx;

   // every pin passes the synchroniser; select idles high
   sdc_pin_sync #(
      .W(3),
      .STAGES(SYNC_STAGES),
      .RST_VAL(3'b001)
   ) u_sync (
      .clk(REF_CLK),
      .srst(SRST),
      .d_in({SI, SCLK, CS_N}),
      .lvl(pin_lvl),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   // named views of the synchronised pins
   assign cs_n = pin_lvl[0];
   assign cs_rise = pin_rise[0];
   assign cs_fall = pin_fall[0];
   assign sclk_rise = pin_rise[1];
   assign sclk_fall = pin_fall[1];
   assign si = pin_lvl[2];

   // frame end checks and the upper byte as it completes
   assign err_set = (st == ST_SHIFT) && cs_rise && (mod8 != 3'h0);
   assign decode_ok = (st == ST_SHIFT) && cs_rise && (mod8 == 3'h0) && ge16;
   assign upper_rx = {sr[6:0], si};

   // pin-side shift register; output floats while deselected
   assign SO_O = so_bit;
   assign SO_OE = ~cs_n;

   // load at select fall, sample on falling clock, drive on rising
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         sr <= 16'h0000;
         so_bit <= 1'b0;
      end else if (cs_fall && st == ST_IDLE) begin
         sr <= out_frame;
         so_bit <= out_frame[`SDC_BIT_RW];
      end else if (st == ST_SHIFT) begin
         if (sclk_fall) begin
            sr <= {sr[14:0], si};
         end else if (up_pend && BYTE_ANS.split) begin
            sr[15:8] <= BYTE_ANS.data;
         end
         if (sclk_rise) begin
            so_bit <= sr[15];
         end
      end
   end

   // modulo-eight bit counter; bits past sixteen pass through to the chain
   always_ff @(posedge REF_CLK) begin
      if (SRST || (cs_fall && st == ST_IDLE)) begin
         mod8 <= 3'h0;
         got_byte <= 1'b0;
         ge16 <= 1'b0;
      end else if (st == ST_SHIFT && sclk_fall) begin
         mod8 <= mod8 + 3'h1;
         if (mod8 == `SDC_BYTE_LAST_CNT) begin
            got_byte <= 1'b1;
            ge16 <= ge16 | got_byte;
         end
      end
   end

   // split marking comes from the byte executor's verdict
   always_ff @(posedge REF_CLK) begin
      if (SRST || (cs_fall && st == ST_IDLE)) begin
         split_frame <= 1'b0;
         up_pend <= 1'b0;
      end else begin
         up_pend <= BYTE_REQ && !BYTE_LAST;
         if (up_pend && BYTE_ANS.split) begin
            split_frame <= 1'b1;
         end
      end
   end

   // frame control: boot snapshot, shifting, decode and fetch
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         st <= ST_BOOT;
         FRM_REQ <= 1'b0;
         FRM_CMD <= '0;
         BYTE_REQ <= 1'b0;
         BYTE_LAST <= 1'b0;
         BYTE_CMD <= 8'h00;
         lo_kind <= 1'b0;
      end else begin
         FRM_REQ <= 1'b0;
         BYTE_REQ <= 1'b0;
         case (st)
            ST_BOOT: begin
               // behave as if a snapshot command had been sent
               FRM_REQ <= 1'b1;
               FRM_CMD <= '{wr: 1'b0, addr: `SDC_ADDR_CMD, data: `SDC_SNAPSHOT_CMD};
               lo_kind <= 1'b0;
               st <= ST_ASK;
            end
            ST_IDLE: begin
               if (cs_fall) begin
                  st <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               // the first byte may be a split command; run it at once
               if (sclk_fall && mod8 == `SDC_BYTE_LAST_CNT && !got_byte && split_en) begin
                  BYTE_REQ <= 1'b1;
                  BYTE_LAST <= 1'b0;
                  BYTE_CMD <= upper_rx;
               end
               if (cs_rise) begin
                  if (decode_ok && split_frame) begin
                     BYTE_REQ <= 1'b1;
                     BYTE_LAST <= 1'b1;
                     BYTE_CMD <= sr[7:0];
                     lo_kind <= 1'b1;
                     st <= ST_ASK;
                  end else if (decode_ok) begin
                     FRM_REQ <= 1'b1;
                     FRM_CMD <= '{wr: sr[`SDC_BIT_RW], addr: sr[`SDC_ADDR_HI:`SDC_ADDR_LO],
                                  data: sr[`SDC_DATA_HI:0]};
                     lo_kind <= 1'b0;
                     st <= ST_ASK;
                  end else begin
                     st <= ST_IDLE;
                  end
               end
            end
            ST_ASK: begin
               st <= ST_LOAD;
            end
            ST_LOAD: begin
               st <= ST_IDLE;
            end
            default: begin
               st <= ST_IDLE;
            end
         endcase
      end
   end

   // next output frame from the answer; it waits for the next select fall
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         out_frame <= 16'h0000;
      end else if (st == ST_LOAD) begin
         if (lo_kind) begin
            out_frame <= {BYTE_ANS.data, 8'h00};
         end else begin
            out_frame <= {^{FRM_CMD.addr, FRM_ANS}, FRM_CMD.addr, FRM_ANS};
         end
      end
   end

   // capture of decoded frames for software
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         last_rx <= 16'h0000;
         frame_cnt <= 8'h00;
      end else if (decode_ok) begin
         last_rx <= sr;
         frame_cnt <= frame_cnt + 8'h01;
      end
   end

   // control register: split protocol enable
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         split_en <= `SDC_CTRL_RST;
      end else if (BUS.wr && BUS.addr == `SDC_REG_CTRL) begin
         split_en <= BUS.wdata[`SDC_CTRL_SPLIT];
      end
   end

   // sticky length error; a new error wins over the clear
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         comm_err <= 1'b0;
      end else if (err_set) begin
         comm_err <= 1'b1;
      end else if (BUS.wr && BUS.addr == `SDC_REG_STATUS && BUS.wdata[`SDC_STAT_ERR]) begin
         comm_err <= 1'b0;
      end
   end
   assign COMM_ERR = comm_err;

   // read data stands in the cycle after the strobe only
   always_ff @(posedge REF_CLK) begin
      if (SRST || !BUS.rd) begin
         BUS_RDATA <= 16'h0000;
      end else if (BUS.addr == `SDC_REG_CTRL) begin
         BUS_RDATA <= {15'h0000, split_en};
      end else if (BUS.addr == `SDC_REG_STATUS) begin
         BUS_RDATA <= {frame_cnt, 5'h00, split_frame, st != ST_IDLE, comm_err};
      end else if (BUS.addr == `SDC_REG_LAST_RX) begin
         BUS_RDATA <= last_rx;
      end else if (BUS.addr == `SDC_REG_LAST_TX) begin
         BUS_RDATA <= out_frame;
      end else begin
         BUS_RDATA <= 16'h0000;
      end
   end

   // checks on the frame engine
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (SRST);

   sequence s_fetch;
      FRM_REQ ##1 (st == ST_LOAD);
   endsequence

   sequence s_lower;
      (BYTE_REQ && BYTE_LAST) ##1 (st == ST_LOAD);
   endsequence

   property p_float_after_select;
      cs_rise |=> !SO_OE;
   endproperty
   a_float_after_select: assert property (p_float_after_select)
      else $error("serial output driven after select rose");

   property p_so_moves_on_edges;
      $changed(SO_O) |-> $past(sclk_rise || cs_fall);
   endproperty
   a_so_moves_on_edges: assert property (p_so_moves_on_edges)
      else $error("serial output changed without clock rise or select fall");

   property p_bad_len_flags;
      err_set |=> comm_err && !FRM_REQ && !BYTE_REQ && st == ST_IDLE;
   endproperty
   a_bad_len_flags: assert property (p_bad_len_flags)
      else $error("odd length frame not discarded with error");

   property p_count_step;
      (st == ST_SHIFT && sclk_fall) |=> mod8 == $past(mod8) + 3'h1;
   endproperty
   a_count_step: assert property (p_count_step)
      else $error("bit counter did not advance");

   property p_decode_fields;
      (decode_ok && !split_frame) |=> FRM_REQ && FRM_CMD.wr == $past(sr[15])
         && FRM_CMD.addr == $past(sr[14:12]) && FRM_CMD.data == $past(sr[11:0]);
   endproperty
   a_decode_fields: assert property (p_decode_fields)
      else $error("decoded command does not match received frame");

   property p_answer_frame;
      s_fetch |=> out_frame[14:12] == $past(FRM_CMD.addr, 2) && out_frame[11:0] == $past(FRM_ANS)
         && out_frame[15] == ^out_frame[14:0];
   endproperty
   a_answer_frame: assert property (p_answer_frame)
      else $error("output frame not built from answer with parity");

   property p_boot_snapshot;
      $fell(SRST) |=> FRM_REQ && !FRM_CMD.wr && FRM_CMD.data == `SDC_SNAPSHOT_CMD && FRM_CMD.addr == `SDC_ADDR_CMD;
   endproperty
   a_boot_snapshot: assert property (p_boot_snapshot)
      else $error("no status snapshot after reset");

   property p_upper_exec;
      (st == ST_SHIFT && sclk_fall && mod8 == 3'h7 && !got_byte && split_en)
         |=> BYTE_REQ && !BYTE_LAST && BYTE_CMD == $past(upper_rx);
   endproperty
   a_upper_exec: assert property (p_upper_exec)
      else $error("upper byte not executed after eight bits");

   property p_upper_insert;
      (up_pend && BYTE_ANS.split && !sclk_fall) |=> sr[15:8] == $past(BYTE_ANS.data) && split_frame;
   endproperty
   a_upper_insert: assert property (p_upper_insert)
      else $error("split answer not placed in lower output byte");

   property p_lower_exec;
      s_lower |=> out_frame == {$past(BYTE_ANS.data), 8'h00};
   endproperty
   a_lower_exec: assert property (p_lower_exec)
      else $error("lower byte answer not in next upper output byte");

   property p_accept_on_rise;
      FRM_REQ && st == ST_ASK && !$past(st == ST_BOOT) |-> $past(cs_rise);
   endproperty
   a_accept_on_rise: assert property (p_accept_on_rise)
      else $error("frame accepted without select rising");

endmodule : sdc_spi_frame

// file: verification/sdc_host_model.sv
// spi master model driving select, clock and data toward the device
`timescale 1ns/1ns
module sdc_host_model (
   input wire logic ref_clk,
   output logic cs_n,
   output logic sclk,
   output logic si,
   input wire logic so
);
   // idle: deselected, clock parked low
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      si = 1'b0;
   end

   // one select window of n bits, msb first; clock low at both select edges
   task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
      rx = '0;
      @(posedge ref_clk) cs_n <= 1'b0;
      repeat (8) @(posedge ref_clk);
      for (int i = n - 1; i >= 0; i--) begin
         si <= tx[i];
         sclk <= 1'b1;
         repeat (4) @(posedge ref_clk);
         // take the bit at the falling clock: the device moved it after the rise
         rx = {rx[30:0], so};
         sclk <= 1'b0;
         repeat (4) @(posedge ref_clk);
      end
      repeat (4) @(posedge ref_clk);
      // raised only once the whole chain has shifted
      cs_n <= 1'b1;
      si <= ~si;
      repeat (10) @(posedge ref_clk);
   endtask : xfer

   // clock and data wiggle while deselected; must be ignored
   task automatic stray(input int n);
      repeat (2 * n) begin
         @(posedge ref_clk) sclk <= ~sclk;
         si <= ~si;
         repeat (3) @(posedge ref_clk);
      end
   endtask : stray
endmodule : sdc_host_model

// file: verification/tb_sdc_spi_frame.sv
// self-checking bench of the spi frame engine with host and register-side models
`timescale 1ns/1ns
`include "sdc_params.svh"
module tb_sdc_spi_frame;
   import sdc_pkg::*;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic cs_n, sclk, si, so_o, so_oe, so_line, byte_req, byte_last, frm_req, comm_err;
   logic so_float = 1'b0;
   sdc_bus_s bus = '0;
   logic [15:0] bus_rdata, exp_out, rd;
   sdc_req_s frm_cmd;
   logic [11:0] frm_ans = '0;
   logic [7:0] byte_cmd;
   sdc_byte_ans_s byte_ans = '0;
   logic [11:0] regs [8];
   logic [31:0] rx;
   int frm_cnt = 0;
   int error_cnt = 0;
   int total_checks = 0;
   int cyc = 0;
   int n0;

   always #50 ref_clk = ~ref_clk;
   // released line toggles so a stale bit never reads as valid
   always @(posedge ref_clk) so_float <= ~so_float;
   assign so_line = so_oe ? so_o : so_float;

   sdc_spi_frame dut (.REF_CLK(ref_clk), .SRST(srst), .CS_N(cs_n), .SCLK(sclk), .SI(si), .SO_O(so_o),
      .SO_OE(so_oe), .BUS(bus), .BUS_RDATA(bus_rdata), .FRM_REQ(frm_req), .FRM_CMD(frm_cmd),
      .FRM_ANS(frm_ans), .BYTE_REQ(byte_req), .BYTE_LAST(byte_last), .BYTE_CMD(byte_cmd),
      .BYTE_ANS(byte_ans), .COMM_ERR(comm_err));
   sdc_host_model host (.ref_clk(ref_clk), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so_line));

   // register content or command feedback for one request
   function automatic logic [11:0] ans_of(sdc_req_s c);
      if (c.addr == `SDC_ADDR_CMD) return ~c.data;
      return c.wr ? c.data : regs[c.addr];
   endfunction : ans_of

   function automatic logic [15:0] out_of(sdc_req_s c);
      logic [11:0] a;
      a = ans_of(c);
      return {^{c.addr, a}, c.addr, a};
   endfunction : out_of

   // bit 11 clear keeps plain frames out of the split code space
   function automatic logic [15:0] rnd16();
      return 16'($urandom) & 16'hF7FF;
   endfunction : rnd16

   // register side: answers the cycle after a request, noise otherwise
   always @(posedge ref_clk) begin
      if (frm_req === 1'b1) begin
         frm_cnt <= frm_cnt + 1;
         frm_ans <= ans_of(frm_cmd);
         if (frm_cmd.wr) regs[frm_cmd.addr] <= frm_cmd.data;
      end else frm_ans <= 12'($urandom);
      if (byte_req === 1'b1) begin
         if (byte_last) byte_ans <= {1'b0, byte_cmd + 8'h01};
         else byte_ans <= {byte_cmd[7:3] == 5'b11001, ~byte_cmd};
      end else byte_ans <= {1'b0, 8'($urandom)};
   end

   task automatic chk16(input logic [15:0] got, input logic [15:0] want, input string what);
      total_checks++;
      if (got !== want) begin
         error_cnt++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
      end
   endtask : chk16

   task automatic chk1(input logic got, input logic want, input string what);
      total_checks++;
      if (got !== want) begin
         error_cnt++;
         $display("unexpected at %0t: %s got %b", $time, what, got);
      end
   endtask : chk1

   task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk) bus <= '0;
   endtask : bus_wr

   task automatic bus_rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge ref_clk) bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk) bus <= '0;
      @(posedge ref_clk) d = bus_rdata;
   endtask : bus_rd

   // one plain frame: returned frame, decoded command, released output
   task automatic frame16(input logic [15:0] tx);
      logic [15:0] want;
      want = exp_out;
      exp_out = out_of(tx);
      host.xfer({16'h0, tx}, 16, rx);
      chk16(rx[15:0], want, "out frame");
      chk16(frm_cmd, tx, "command");
      chk1(so_oe, 1'b0, "so enable");
   endtask : frame16

   // nop first, then a split frame with upper and lower byte commands
   task automatic split(input logic [2:0] u, input logic [7:0] lo);
      logic [7:0] up;
      up = {5'b11001, u};
      frame16({1'b0, `SDC_ADDR_CMD, 12'h700});
      host.xfer({16'h0, up, lo}, 16, rx);
      chk16(rx[15:0], {exp_out[15:8], ~up}, "split frame");
      exp_out = {lo + 8'h01, 8'h00};
   endtask : split

   // chain frame: head is our answer, then upstream bits pass through
   task automatic chain(input logic [15:0] w, input int n);
      logic [15:0] c, want;
      logic [31:0] tail;
      c = rnd16();
      want = exp_out;
      exp_out = out_of(c);
      host.xfer({w, c}, n, rx);
      tail = rx << (48 - n);
      chk16(rx[n-1 -: 16], want, "chain head");
      chk16(tail[31:16], w << (32 - n), "chain pass");
      chk16(frm_cmd, c, "chain cmd");
   endtask : chain

   task automatic end_sim();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_sim

   // hang guard well above the expected run length
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         error_cnt++;
         end_sim();
      end
   end

   initial begin
      void'($urandom(80));
      for (int i = 0; i < 8; i++) regs[i] = '0;
      exp_out = out_of({1'b0, `SDC_ADDR_CMD, `SDC_SNAPSHOT_CMD});
      repeat (12) @(posedge ref_clk);
      srst <= 1'b0;
      repeat (8) @(posedge ref_clk);
      bus_rd(`SDC_REG_CTRL, rd);
      chk16(rd, {15'h0, `SDC_CTRL_RST}, "ctrl reset");
      bus_wr(4'hF, 16'hFFFF);
      bus_rd(4'hF, rd);
      chk16(rd, 16'h0000, "unmapped");
      // write, read back, then a new command in the read's answer frame
      frame16({1'b1, 3'h5, 12'h3A5});
      frame16({1'b0, 3'h5, 12'h000});
      frame16({1'b1, 3'h6, 12'h0C3});
      bus_rd(`SDC_REG_LAST_RX, rd);
      chk16(rd, {1'b1, 3'h6, 12'h0C3}, "last rx");
      bus_rd(`SDC_REG_LAST_TX, rd);
      chk16(rd, exp_out, "next out");
      host.stray(6);
      n0 = frm_cnt;
      frame16(rnd16());
      chk16(16'(frm_cnt), 16'(n0 + 1), "one decode");
      // bad length: no decode, sticky error, cleared by writing one
      host.xfer(32'h0ABC, 12, rx);
      chk1(comm_err, 1'b1, "length error");
      bus_rd(`SDC_REG_STATUS, rd);
      chk1(rd[`SDC_STAT_ERR], 1'b1, "status err");
      // boot request is counted by the model but is no decoded frame
      chk16({8'h00, rd[15:8]}, 16'(frm_cnt - 1), "frame count");
      bus_wr(`SDC_REG_STATUS, 16'h0001);
      repeat (2) @(posedge ref_clk);
      chk1(comm_err, 1'b0, "error clear");
      host.xfer(32'h0, 8, rx);
      chk1(comm_err, 1'b0, "byte frame");
      chk16(16'(frm_cnt), 16'(n0 + 1), "no decode");
      frame16(rnd16());
      chain(16'h0000, 24);
      chain(rnd16(), 32);
      // nop for the next device; its own answer is never compared
      chain({1'b0, `SDC_ADDR_CMD, 12'h700}, 32);
      for (int i = 0; i < 24; i++) begin
         if ($urandom % 4 == 0) split(3'($urandom), 8'($urandom));
         else frame16(rnd16());
      end
      frame16(rnd16());
      end_sim();
   end
endmodule : tb_sdc_spi_frame
